// file: include/fmcfg_pkg.sv
// Package with register map, field layout and constants of the config bank
package fmcfg_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int TEMP_W = 8;
  localparam int FAN_N  = 4;

  // Register offsets
  localparam logic [7:0] PIN_OT_CFG_ADDR = 8'h7D;
  localparam logic [7:0] FTEST_ONE_ADDR  = 8'h7E;
  localparam logic [7:0] FTEST_TWO_ADDR  = 8'h7F;
  localparam logic [7:0] TWOS_CFG_ADDR   = 8'h7C;
  localparam logic [7:0] LOCK_CFG_ADDR   = 8'h40;
  localparam logic [7:0] FAN_MAX_ADDR0   = 8'h38;
  localparam logic [7:0] FAN_MAX_ADDR1   = 8'h39;
  localparam logic [7:0] FAN_MAX_ADDR2   = 8'h3A;

  // Field positions in the pin and overtemp, twos and lock registers
  localparam int PIN_FN_LO   = 0;
  localparam int OT_DIS_BIT  = 2;
  localparam int MAXFULL_BIT = 3;
  localparam int BYPASS_BIT  = 5;
  localparam int TWOS_BIT    = 0;
  localparam int LOCK_BIT    = 1;

  // Writable bits of the pin and overtemp register
  localparam logic [7:0] PIN_OT_MASK = 8'h2F;

  // Reset values
  localparam logic [7:0] PIN_OT_RST  = 8'h00;
  localparam logic [7:0] FTEST_RST   = 8'h00;
  localparam logic [7:0] FAN_MAX_RST = 8'hFF;
  localparam logic [7:0] READ_ZERO   = 8'h00;

  // Disabled overtemp limit codes: -64 C offset-64, -128 C twos complement
  localparam logic [7:0] OT_OFF_OFS64 = 8'h00;
  localparam logic [7:0] OT_OFF_TWOS  = 8'h80;
  localparam logic [7:0] FULL_SPEED   = 8'hFF;

  // Core voltage scaling: bypass full scale 2.2965 V, attenuated scale
  localparam logic [7:0] VCODE_MAX = 8'hFF;

  // Shared pin functions
  typedef enum logic [1:0] {
    FMCFG_FN_TACH  = 2'h0,
    FMCFG_FN_OT    = 2'h1,
    FMCFG_FN_ALERT = 2'h2,
    FMCFG_FN_GPIO  = 2'h3
  } fmcfg_pin_fn_t;

endpackage : fmcfg_pkg

// file: rtl/fmcfg_ot_chan.sv
// One temperature channel overtemp comparator with limit disable detect
`timescale 1ns/1ns
`default_nettype none
module fmcfg_ot_chan
  import fmcfg_pkg::*;
#(
  parameter int W = TEMP_W
) (
  input  wire logic [W-1:0] temp,
  input  wire logic [W-1:0] limit,
  input  wire logic         twos_mode,
  output logic              over
);

  logic         disabled;
  logic [W-1:0] t_cmp;
  logic [W-1:0] l_cmp;

  // Twos mode flips sign bit so unsigned compare works
  always_comb begin
    t_cmp = twos_mode ? {~temp[W-1], temp[W-2:0]} : temp;
    l_cmp = twos_mode ? {~limit[W-1], limit[W-2:0]} : limit;
    disabled = twos_mode ? (limit == OT_OFF_TWOS) : (limit == OT_OFF_OFS64);
    over = !disabled && (t_cmp > l_cmp);
  end

endmodule : fmcfg_ot_chan
`default_nettype wire

// file: rtl/fmcfg_vscale.sv
// Core voltage code scaling with optional attenuator bypass
`timescale 1ns/1ns
`default_nettype none
module fmcfg_vscale
  import fmcfg_pkg::*;
(
  input  wire logic [7:0] raw_code,
  input  wire logic       bypass,
  output logic [7:0]      code
);

  logic [8:0] half;

  // bypass uses full 0x00..0xFF span of 0 V..2.2965 V
  always_comb begin
    half = {1'b0, raw_code} + 9'h001;
    if (bypass) begin
      code = raw_code;
    end else begin
      code = half[8:1];
    end
    if (code > VCODE_MAX) begin
      code = VCODE_MAX;
    end
  end

endmodule : fmcfg_vscale
`default_nettype wire

// file: rtl/fmcfg_top.sv
// Pin and overtemp configuration bank with its consumers
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// - Two bits route shared pin function
// - Disable bit suppresses overtemp output everywhere
// - Lowest limit code disables channel overtemp
// - Select clear: overtemp forces full speed
// - Select set: overtemp uses per-fan maximum on the first three fans, full speed on the fourth
// - Bypass gives 0..2.2965 V full scale
// - Lock bit makes register read-only
// - Two test registers read-only, zero
// - Register powers up all zeros
// - Twos select sets limit encoding
module fmcfg_top
  import fmcfg_pkg::*;
#(
  parameter int NCH = 3
) (
  input  wire logic                   clk,
  input  wire logic                   rst_b,
  input  wire logic [ADDR_W-1:0]      addr,
  input  wire logic [DATA_W-1:0]      wdata,
  input  wire logic                   wr,
  input  wire logic                   rd,
  output logic [DATA_W-1:0]           rdata,
  input  wire logic [NCH*TEMP_W-1:0]  temp_in,
  input  wire logic [NCH*TEMP_W-1:0]  ot_limit_in,
  input  wire logic [7:0]             core_raw_in,
  input  wire logic [FAN_N*8-1:0]     fan_duty_in,
  input  wire logic                   shared_pin_in,
  input  wire logic                   alert_req,
  input  wire logic                   gpio_oe_req,
  input  wire logic                   gpio_out_req,
  output logic                        shared_pin_out,
  output logic                        shared_pin_oe,
  output logic                        fan4_tach_input,
  output logic                        gpio_in,
  output logic                        overtemp_ext_in,
  output logic                        overtemp_active,
  output logic [FAN_N*8-1:0]          fan_duty_out,
  output logic [7:0]                  core_code
);

  typedef struct packed {
    logic [7:0]           cfg;
    logic                 twos;
    logic                 lock;
    logic [3*8-1:0]       fan_max;
    logic [DATA_W-1:0]    rdata;
    logic                 pin_s1;
    logic                 pin_s2;
    logic                 pin_out;
    logic                 pin_oe;
    logic                 tach;
    logic                 gpin;
    logic                 ot_in;
    logic                 ot_act;
    logic [FAN_N*8-1:0]   duty;
    logic [7:0]           vcode;
  } fmcfg_state_t;

  fmcfg_state_t s_q;
  fmcfg_state_t s_d;

  logic [NCH-1:0] ch_over;
  logic [7:0]     vcode_w;
  logic           any_over;
  logic           ot_enabled;
  fmcfg_pin_fn_t  pin_fn;

  // Per-channel comparators
  genvar gi;
  generate
    for (gi = 0; gi < NCH; gi++) begin : g_ch
      fmcfg_ot_chan #(.W(TEMP_W)) u_ch (
        .temp      (temp_in[gi*TEMP_W +: TEMP_W]),
        .limit     (ot_limit_in[gi*TEMP_W +: TEMP_W]),
        .twos_mode (s_q.twos),
        .over      (ch_over[gi])
      );
    end
  endgenerate

  // Core voltage scaling
  fmcfg_vscale u_vs (
    .raw_code (core_raw_in),
    .bypass   (s_q.cfg[BYPASS_BIT]),
    .code     (vcode_w)
  );

  assign pin_fn     = fmcfg_pin_fn_t'(s_q.cfg[PIN_FN_LO +: 2]);
  assign ot_enabled = !s_q.cfg[OT_DIS_BIT];
  assign any_over   = ot_enabled && (|ch_over);

  // Next state
  always_comb begin
    s_d = s_q;
    s_d.pin_s1 = shared_pin_in;
    s_d.pin_s2 = s_q.pin_s1;
    // Register writes
    if (wr) begin
      case (addr)
        PIN_OT_CFG_ADDR: begin
          if (!s_q.lock) begin
            s_d.cfg = wdata & PIN_OT_MASK;
          end
        end
        TWOS_CFG_ADDR: begin
          if (!s_q.lock) begin
            s_d.twos = wdata[TWOS_BIT];
          end
        end
        LOCK_CFG_ADDR: begin
          // Lock is sticky until reset
          s_d.lock = s_q.lock | wdata[LOCK_BIT];
        end
        FAN_MAX_ADDR0: s_d.fan_max[0 +: 8]  = wdata;
        FAN_MAX_ADDR1: s_d.fan_max[8 +: 8]  = wdata;
        FAN_MAX_ADDR2: s_d.fan_max[16 +: 8] = wdata;
        default: begin
        end
      endcase
    end
    // Register reads, data the next cycle
    s_d.rdata = READ_ZERO;
    if (rd) begin
      case (addr)
        PIN_OT_CFG_ADDR: s_d.rdata = s_q.cfg & PIN_OT_MASK;
        FTEST_ONE_ADDR:  s_d.rdata = FTEST_RST;
        FTEST_TWO_ADDR:  s_d.rdata = FTEST_RST;
        TWOS_CFG_ADDR:   s_d.rdata = {7'h00, s_q.twos};
        LOCK_CFG_ADDR:   s_d.rdata = {6'h00, s_q.lock, 1'b0};
        FAN_MAX_ADDR0:   s_d.rdata = s_q.fan_max[0 +: 8];
        FAN_MAX_ADDR1:   s_d.rdata = s_q.fan_max[8 +: 8];
        FAN_MAX_ADDR2:   s_d.rdata = s_q.fan_max[16 +: 8];
        default:         s_d.rdata = READ_ZERO;
      endcase
    end
    s_d.pin_out = 1'b0;
    s_d.pin_oe  = 1'b0;
    s_d.tach    = 1'b0;
    s_d.gpin    = 1'b0;
    s_d.ot_in   = 1'b0;
    case (pin_fn)
      FMCFG_FN_TACH: begin
        s_d.tach = s_q.pin_s2;
      end
      FMCFG_FN_OT: begin
        // Open-drain, active low overtemp signal
        s_d.pin_oe = any_over;
        s_d.ot_in  = !s_q.pin_s2;
      end
      FMCFG_FN_ALERT: begin
        s_d.pin_oe = alert_req;
      end
      FMCFG_FN_GPIO: begin
        s_d.pin_oe  = gpio_oe_req;
        s_d.pin_out = gpio_out_req;
        s_d.gpin    = s_q.pin_s2;
      end
      default: begin
      end
    endcase
    s_d.ot_act = any_over;
    // Fan override on overtemp
    s_d.duty = fan_duty_in;
    if (any_over) begin
      for (int f = 0; f < FAN_N; f++) begin
        if (s_q.cfg[MAXFULL_BIT] && f < 3) begin
          s_d.duty[f*8 +: 8] = s_q.fan_max[f*8 +: 8];
        end else begin
          s_d.duty[f*8 +: 8] = FULL_SPEED;
        end
      end
    end
    s_d.vcode = vcode_w;
  end

  // State register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_q         <= '0;
      s_q.cfg     <= PIN_OT_RST;
      s_q.fan_max <= {3{FAN_MAX_RST}};
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from flops
  assign rdata           = s_q.rdata;
  assign shared_pin_out  = s_q.pin_out;
  assign shared_pin_oe   = s_q.pin_oe;
  assign fan4_tach_input = s_q.tach;
  assign gpio_in         = s_q.gpin;
  assign overtemp_ext_in = s_q.ot_in;
  assign overtemp_active = s_q.ot_act;
  assign fan_duty_out    = s_q.duty;
  assign core_code       = s_q.vcode;

endmodule : fmcfg_top
`default_nettype wire

// file: verif/fmcfg_properties.sv
// Checker of the pin and overtemp bank ports
`timescale 1ns/1ns
`default_nettype none
module fmcfg_props
  import fmcfg_pkg::*;
(
  input wire logic               clk,
  input wire logic               rst_b,
  input wire logic [ADDR_W-1:0]  addr,
  input wire logic [DATA_W-1:0]  wdata,
  input wire logic               wr,
  input wire logic               rd,
  input wire logic [DATA_W-1:0]  rdata,
  input wire logic [7:0]         core_raw_in,
  input wire logic [FAN_N*8-1:0] fan_duty_in,
  input wire logic               gpio_oe_req,
  input wire logic               shared_pin_oe,
  input wire logic               fan4_tach_input,
  input wire logic               gpio_in,
  input wire logic               overtemp_ext_in,
  input wire logic               overtemp_active,
  input wire logic [FAN_N*8-1:0] fan_duty_out,
  input wire logic [7:0]         core_code
);
  logic [7:0] cfg_q;
  logic       lock_q;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // Shadow of the config register, frozen once the lock is set
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg_q  <= PIN_OT_RST;
      lock_q <= 1'b0;
    end else if (wr) begin
      if (addr == PIN_OT_CFG_ADDR && !lock_q) cfg_q <= wdata & PIN_OT_MASK;
      if (addr == LOCK_CFG_ADDR && wdata[LOCK_BIT]) lock_q <= 1'b1;
    end
  end
  cfg_readback_a: assert property ($past(rd) && $past(addr) == 8'h7D
    |-> rdata == $past(cfg_q)) else $error("config readback wrong");
  test_reg_ro_a: assert property ($past(rd) && $past(addr) >= 8'h7E
    |-> rdata == 8'h00) else $error("test register not zero");
  ot_off_a: assert property ($past(cfg_q[2]) |-> !overtemp_active)
    else $error("overtemp active while disabled");
  duty_pass_a: assert property ($past(cfg_q[2], 2) && $past(cfg_q[2])
    |-> fan_duty_out == $past(fan_duty_in)) else $error("duty overridden");
  tach_quiet_a: assert property ($past(cfg_q[1:0]) == 2'h0
    |-> !shared_pin_oe && !gpio_in && !overtemp_ext_in)
    else $error("pin busy in tach mode");
  not_tach_a: assert property ($past(cfg_q[1:0]) != 2'h0
    |-> !fan4_tach_input) else $error("tach seen outside tach mode");
  gpio_dir_a: assert property ($past(cfg_q[1:0]) == 2'h3
    |-> shared_pin_oe == $past(gpio_oe_req)) else $error("gpio enable wrong");
  bypass_a: assert property ($past(cfg_q[5])
    |-> core_code == $past(core_raw_in)) else $error("bypass code wrong");
  cover property (wr && addr == PIN_OT_CFG_ADDR && lock_q);
  cover property (overtemp_active);
  cover property (rd && addr == FTEST_TWO_ADDR);
endmodule : fmcfg_props
`default_nettype wire

// file: verif/fmcfg_host.sv
// Host model issuing accesses on the plain register port
`timescale 1ns/1ns
`default_nettype none
module fmcfg_host
  import fmcfg_pkg::*;
(
  input  wire logic              clk,
  input  wire logic [DATA_W-1:0] rdata,
  output logic [ADDR_W-1:0]      addr,
  output logic [DATA_W-1:0]      wdata,
  output logic                   wr,
  output logic                   rd
);
  initial {addr, wdata, wr, rd} = '0;
  // One-cycle write, data turned over on release
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    {addr, wdata, wr} <= {a, d, 1'b1};
    @(posedge clk);
    {wdata, wr} <= {~d, 1'b0};
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    {addr, rd} <= {a, 1'b1};
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : rd_reg
endmodule : fmcfg_host
`default_nettype wire

// file: verif/fmcfg_top_tb.sv
// Self-checking bench of the pin and overtemp bank
`timescale 1ns/1ns
`default_nettype none
module fmcfg_top_tb import fmcfg_pkg::*;;
  logic              clk = 1'b0;
  logic              rst_b = 1'b0;
  logic [7:0]        addr, wdata, rdata, rv, code;
  logic              wr, rd, oe, tach, gin, ot, pout, oin;
  logic              pin = 1'b1, alert = 1'b0, goe = 1'b1, gout = 1'b1;
  logic [23:0]       temp = 24'h605050, lim = 24'h000040;
  logic [7:0]        raw = 8'h00;
  logic [31:0]       din = 32'h11223344, dout;
  int                n_mismatch = 0, samples_checked = 0;
  always #25 clk = ~clk;
  fmcfg_host u_host (.clk(clk), .rdata(rdata), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd));
  fmcfg_top u_dut (.clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .temp_in(temp), .ot_limit_in(lim),
    .core_raw_in(raw), .fan_duty_in(din), .shared_pin_in(pin),
    .alert_req(alert), .gpio_oe_req(goe), .gpio_out_req(gout),
    .shared_pin_out(pout), .shared_pin_oe(oe), .fan4_tach_input(tach),
    .gpio_in(gin), .overtemp_ext_in(oin), .overtemp_active(ot),
    .fan_duty_out(dout), .core_code(code));
  task automatic chk(input string nm, input logic [31:0] e, g);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    u_host.rd_reg(a, rv);
    chk("rdata", {24'h0, e}, {24'h0, rv});
  endtask : rchk
  // Write then let outputs settle
  task automatic wrs(input logic [7:0] a, input logic [7:0] d);
    u_host.wr_reg(a, d);
    repeat (5) @(posedge clk);
    #1;
  endtask : wrs
  task automatic stim(input logic [23:0] l, input logic [7:0] r);
    @(posedge clk);
    {lim, raw} <= {l, r};
    repeat (5) @(posedge clk);
    #1;
  endtask : stim
  task automatic wrap_up;
    $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : wrap_up
  initial begin
    #100000;
    n_mismatch++;
    wrap_up();
  end
  // Register, pin routing and overtemp response sequence
  initial begin
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    rchk(PIN_OT_CFG_ADDR, 8'h00);
    rchk(FTEST_ONE_ADDR, 8'h00);
    rchk(8'h01, 8'h00);
    wrs(PIN_OT_CFG_ADDR, 8'hFF);
    rchk(PIN_OT_CFG_ADDR, 8'h2F);
    for (int c = 0; c < 4; c++) begin
      wrs(PIN_OT_CFG_ADDR, 8'(c));
      chk("pin", {29'h0, c == 0, c == 3, c[0]}, {29'h0, tach, gin, oe});
      chk("pout", {31'h0, c == 3}, {31'h0, pout});
    end
    // Pin pulled low in overtemp mode reads as external overtemp
    pin <= 1'b0;
    wrs(PIN_OT_CFG_ADDR, 8'h01);
    chk("otin", 32'h1, {31'h0, oin});
    pin <= 1'b1;
    wrs(PIN_OT_CFG_ADDR, 8'h00);
    chk("ot", 32'h1, {31'h0, ot});
    chk("full", 32'hFFFFFFFF, dout);
    wrs(FAN_MAX_ADDR0, 8'h80);
    wrs(FAN_MAX_ADDR1, 8'h90);
    wrs(FAN_MAX_ADDR2, 8'hA0);
    wrs(PIN_OT_CFG_ADDR, 8'h08);
    chk("max", 32'hFFA09080, dout);
    wrs(PIN_OT_CFG_ADDR, 8'h0C);
    chk("ot", 32'h0, {31'h0, ot});
    chk("pass", 32'h11223344, dout);
    wrs(PIN_OT_CFG_ADDR, 8'h00);
    stim(24'h000000, 8'h00);
    chk("ot", 32'h0, {31'h0, ot});
    wrs(TWOS_CFG_ADDR, 8'h01);
    chk("ot", 32'h1, {31'h0, ot});
    stim(24'h808080, 8'hC8);
    chk("ot", 32'h0, {31'h0, ot});
    wrs(PIN_OT_CFG_ADDR, 8'h20);
    chk("code", 32'hC8, {24'h0, code});
    wrs(LOCK_CFG_ADDR, 8'h02);
    wrs(PIN_OT_CFG_ADDR, 8'h03);
    rchk(PIN_OT_CFG_ADDR, 8'h20);
    wrs(FTEST_TWO_ADDR, 8'h55);
    rchk(FTEST_TWO_ADDR, 8'h00);
    wrap_up();
  end
endmodule : fmcfg_top_tb
bind fmcfg_top fmcfg_props u_props (.clk, .rst_b, .addr, .wdata, .wr, .rd,
  .rdata, .core_raw_in, .fan_duty_in, .gpio_oe_req, .shared_pin_oe,
  .fan4_tach_input, .gpio_in, .overtemp_ext_in, .overtemp_active,
  .fan_duty_out, .core_code);
`default_nettype wire
